// ===== common/sfcc_pkg.sv
// Constants shared by the serial port flag, clocking and configuration block.
// Assumes a 50 MHz system clock and the byte-wide special function register port.
package sfcc_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_CTRL = 8'hf8;
    localparam logic [7:0] ADDR_CFG = 8'ha1;
    localparam logic [7:0] ADDR_RATE = 8'ha2;
    localparam logic [7:0] ADDR_DATA = 8'ha3;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h06;
    localparam logic [7:0] CFG_RST = 8'h07;
    localparam logic [7:0] RATE_RST = 8'h00;
    // Control register fields
    localparam int CTL_DONE = 7;
    localparam int CTL_WRITE_COLLISION_FLAG = 6;
    localparam int CTL_MODE_FAULT_FLAG = 5;
    localparam int CTL_OVR = 4;
    localparam int CTL_SEL_HI = 3;
    localparam int CTL_SEL_LO = 2;
    localparam int CTL_TXE = 1;
    localparam int CTL_EN = 0;
    // Configuration register fields
    localparam int CFG_BUSY = 7;
    localparam int CFG_MST = 6;
    localparam int CFG_CPHA = 5;
    localparam int CFG_CPOL = 4;
    localparam int CFG_SEL = 3;
    localparam int CFG_PIN = 2;
    localparam int CFG_SHIFT_EMPTY_BIT = 1;
    localparam int CFG_RXE = 0;
    // Bit rate ceiling and the shortest half period it allows
    localparam int SYS_HZ = 50_000_000;
    localparam int MAX_BIT_HZ = 12_500_000;
    localparam int HALF_MIN = (SYS_HZ + 2 * MAX_BIT_HZ - 1) / (2 * MAX_BIT_HZ);
    localparam logic [7:0] HALF_MIN_LAST = 8'(HALF_MIN - 1);
    // Sixteen clock edges per byte, half periods counted from zero
    localparam logic [4:0] HALF_LAST = 5'h0f;
    // Master engine states
    typedef enum logic [1:0] {
        SFCC_IDLE = 2'b01,
        SFCC_RUN = 2'b10
    } sfcc_state_t;
endpackage : sfcc_pkg

// ===== src/sfcc_core.sv
// Byte-wide serial port: flags, clock phase and polarity, bit rate, configuration.
// Assumes the core drives one register access per cycle; pins are resolved outside.
// Notes on behaviour
// - Transfer-done flag sets at the end of every byte, master or slave.
// - Any set event flag raises the interrupt; only software clears flags.
// - Data write with full transmit buffer sets write collision and is dropped.
// - Multi-master select pulled low: mode fault, master and port enable cleared.
// - Slave byte done with unread receive byte: overrun, old byte kept.
// - Clock phase 0 centres data on first edge, 1 on second edge.
// - Clock polarity sets the idle level of the serial clock.
// - Master and slave must share the same phase and polarity.
// - Clock rate register steers only the master; slave ignores it.
// - Master bit rate never above a quarter of system clock, 12.5 MHz.
// - Busy bit reads 1 while any transfer is in progress.
// - Master enable 0 selects slave role, 1 selects master role.
// - Two parts of this family should both use clock phase 0.
// - Core reaches the port through control, data, configuration, rate registers.
// - Selected bit follows the filtered select line; raw bit shows the pin.
// - Slave shift-empty sets when idle, clears on load or clock edge.
// - Slave receive-empty is 1 once read, 0 while a byte waits.
// - Slave samples mid-bit; master samples the pin two clocks before bit end.
`timescale 1ns/10ps
module sfcc_core (
    input wire logic i_clk_sys, // System clock, 50 MHz
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic [7:0] i_sfr_addr, // Register address
    input wire logic i_sfr_wr, // Write strobe
    input wire logic i_sfr_rd, // Read strobe
    input wire logic [7:0] i_sfr_wdata, // Write data
    output logic [7:0] o_sfr_rdata, // Read data, one cycle after strobe
    input wire logic i_irq_en, // Port interrupt enable from core
    output logic o_irq, // Interrupt request
    input wire logic i_sck, // Serial clock pin in, slave side
    output logic o_sck, // Serial clock out
    output logic o_sck_oe_n, // Serial clock drive, low drives
    input wire logic i_mosi, // Master-out pin in
    output logic o_mosi, // Master-out pin out
    output logic o_mosi_oe_n, // Master-out drive, low drives
    input wire logic i_miso, // Master-in pin in
    output logic o_miso, // Master-in pin out
    output logic o_miso_oe_n, // Master-in drive, low drives
    input wire logic i_nss, // Slave select line in
    output logic o_nss, // Slave select line out
    output logic o_nss_oe_n // Slave select drive, low drives
);
    typedef struct packed {
        sfcc_pkg::sfcc_state_t st;
        logic [4:0] half;
        logic [7:0] div;
        logic [7:0] sh;
        logic [7:0] txb;
        logic [7:0] rxb;
        logic [7:0] ckr;
        logic [1:0] select_mode_field;
        logic [2:0] sck_s;
        logic [2:0] tgl_s;
        logic [2:0] nss_s;
        logic [1:0] miso_s;
        logic transfer_done_flag, write_collision_flag, mode_fault_flag, ovr, en, mst, cpha, cpol;
        logic txe, rxe, shift_empty_bit, sbusy, act, nssf;
        logic sck, mosi, miso, nsso, irq;
        logic sck_oe_n, mosi_oe_n, miso_oe_n, nss_oe_n;
        logic [7:0] rdata;
    } sfcc_sys_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
        logic [7:0] byte_q;
        logic tgl;
    } sfcc_link_t;

    localparam sfcc_sys_t SYS_RST = '{
        st: sfcc_pkg::SFCC_IDLE,
        select_mode_field: sfcc_pkg::CTRL_RST[sfcc_pkg::CTL_SEL_HI:sfcc_pkg::CTL_SEL_LO],
        txe: sfcc_pkg::CTRL_RST[sfcc_pkg::CTL_TXE],
        rxe: sfcc_pkg::CFG_RST[sfcc_pkg::CFG_RXE],
        shift_empty_bit: sfcc_pkg::CFG_RST[sfcc_pkg::CFG_SHIFT_EMPTY_BIT],
        nssf: sfcc_pkg::CFG_RST[sfcc_pkg::CFG_PIN],
        nss_s: 3'h7,
        ckr: sfcc_pkg::RATE_RST,
        sck_oe_n: 1'b1,
        mosi_oe_n: 1'b1,
        miso_oe_n: 1'b1,
        nss_oe_n: 1'b1,
        default: '0
    };

    sfcc_sys_t r, n;
    sfcc_link_t l, ln;
    logic fault, wr_ctl, wr_cfg, wr_rate, wr_dat, rd_dat, done, any_edge, drv_edge;
    logic [7:0] half_last;

    // True when a synchronised level moved between its two older stages
    function automatic logic moved(input logic [1:0] s);
        moved = s[0] ^ s[1];
    endfunction : moved

    // Link side: runs on the slave's sample edge, phase and polarity fold into it
    wire lclk = i_sck ^ r.cpol ^ r.cpha;
    // Counter restarts whenever the port is not an active slave
    wire lrst = i_rst | ~r.act;

    // Shift in at every sample edge, hand the byte over with a toggle
    always_comb begin
        ln = l;
        ln.sh = {l.sh[5:0], i_mosi};
        ln.cnt = l.cnt + 3'h1;
        if (l.cnt == 3'h7) begin
            ln.byte_q = {l.sh, i_mosi};
            ln.tgl = ~l.tgl;
        end
    end

    always_ff @(posedge lclk or posedge lrst) begin
        if (lrst) begin
            l <= '0;
        end else begin
            l <= ln;
        end
    end

    // System side: register port, master engine, slave bookkeeping
    always_comb begin
        n = r;
        n.sck_s = {r.sck_s[1:0], i_sck};
        n.tgl_s = {r.tgl_s[1:0], l.tgl};
        n.nss_s = {r.nss_s[1:0], i_nss};
        n.miso_s = {r.miso_s[0], i_miso};
        // Two agreeing samples filter select glitches
        if (r.nss_s[2] == r.nss_s[1]) begin
            n.nssf = r.nss_s[1];
        end
        wr_ctl = i_sfr_wr && (i_sfr_addr == sfcc_pkg::ADDR_CTRL);
        wr_cfg = i_sfr_wr && (i_sfr_addr == sfcc_pkg::ADDR_CFG);
        wr_rate = i_sfr_wr && (i_sfr_addr == sfcc_pkg::ADDR_RATE);
        wr_dat = i_sfr_wr && (i_sfr_addr == sfcc_pkg::ADDR_DATA);
        rd_dat = i_sfr_rd && (i_sfr_addr == sfcc_pkg::ADDR_DATA);
        fault = r.en & r.mst & (r.select_mode_field == 2'b01) & ~r.nssf;
        done = r.act & moved(r.tgl_s[2:1]);
        any_edge = moved(r.sck_s[2:1]);
        drv_edge = any_edge & ((r.sck_s[1] ^ r.cpol ^ r.cpha) == 1'b0);
        // Never faster than the bit-rate ceiling
        half_last = (r.ckr < sfcc_pkg::HALF_MIN_LAST) ? sfcc_pkg::HALF_MIN_LAST : r.ckr;
        // Software writes; hardware sets further down win over clears
        if (wr_ctl) begin
            n.transfer_done_flag = i_sfr_wdata[sfcc_pkg::CTL_DONE];
            n.write_collision_flag = i_sfr_wdata[sfcc_pkg::CTL_WRITE_COLLISION_FLAG];
            n.mode_fault_flag = i_sfr_wdata[sfcc_pkg::CTL_MODE_FAULT_FLAG];
            n.ovr = i_sfr_wdata[sfcc_pkg::CTL_OVR];
            n.select_mode_field = i_sfr_wdata[sfcc_pkg::CTL_SEL_HI:sfcc_pkg::CTL_SEL_LO];
            n.en = i_sfr_wdata[sfcc_pkg::CTL_EN];
        end
        if (wr_cfg) begin
            n.mst = i_sfr_wdata[sfcc_pkg::CFG_MST];
            n.cpha = i_sfr_wdata[sfcc_pkg::CFG_CPHA];
            n.cpol = i_sfr_wdata[sfcc_pkg::CFG_CPOL];
        end
        if (wr_rate) begin
            n.ckr = i_sfr_wdata;
        end
        if (wr_dat) begin
            if (r.txe) begin
                n.txb = i_sfr_wdata;
                n.txe = 1'b0;
            end else begin
                n.write_collision_flag = 1'b1;
            end
        end
        if (rd_dat) begin
            n.rxe = 1'b1;
        end
        // Master engine: sixteen half periods, one more when phase is 1
        case (r.st)
            sfcc_pkg::SFCC_IDLE: begin
                n.sck = r.cpol;
                if (r.en && r.mst && !r.txe) begin
                    n.st = sfcc_pkg::SFCC_RUN;
                    n.sh = r.txb;
                    n.txe = 1'b1;
                    n.mosi = r.txb[7];
                    n.half = 5'h00;
                    n.div = 8'h00;
                end
            end
            sfcc_pkg::SFCC_RUN: begin
                if (r.div < half_last) begin
                    n.div = r.div + 8'h01;
                end else begin
                    n.div = 8'h00;
                    n.half = r.half + 5'h01;
                    if (r.half <= sfcc_pkg::HALF_LAST) begin
                        n.sck = ~r.sck;
                    end
                    // Sample in the last cycle of each bit, then present the next; phase 1 keeps bit 7 over edge one
                    if ((r.half[0] != r.cpha) && (r.half != 5'h00)) begin
                        n.sh = {r.sh[6:0], r.miso_s[1]};
                        n.mosi = r.sh[6];
                    end
                    if (r.half == sfcc_pkg::HALF_LAST + {4'h0, r.cpha}) begin
                        n.st = sfcc_pkg::SFCC_IDLE;
                        n.transfer_done_flag = 1'b1;
                        n.rxb = {r.sh[6:0], r.miso_s[1]};
                    end
                end
            end
            default: begin
                n.st = sfcc_pkg::SFCC_IDLE;
            end
        endcase
        if (!r.en) begin
            n.st = sfcc_pkg::SFCC_IDLE;
        end
        // Slave bookkeeping off synchronised clock and the byte toggle
        n.act = n.en & ~n.mst & ((n.select_mode_field == 2'b00) | ~n.nssf);
        if (r.act) begin
            if (any_edge) begin
                n.shift_empty_bit = 1'b0;
            end
            // Phase 0 ends a byte on a drive edge, which must not read as a new transfer
            if (any_edge && !(drv_edge && !r.cpha)) begin
                n.sbusy = 1'b1;
            end
            // Phase 1 shows each bit from its first edge, phase 0 before it
            if (drv_edge) begin
                if (r.cpha) begin
                    n.miso = r.sh[7];
                end
                n.sh = {r.sh[6:0], 1'b0};
            end
            if (done) begin
                n.transfer_done_flag = 1'b1;
                n.sbusy = 1'b0;
                n.shift_empty_bit = 1'b1;
                if (r.rxe) begin
                    n.rxb = l.byte_q;
                    n.rxe = 1'b0;
                end else begin
                    n.ovr = 1'b1;
                end
            end
            if (n.shift_empty_bit && !r.txe) begin
                n.sh = r.txb;
                n.txe = 1'b1;
                n.shift_empty_bit = 1'b0;
            end
            if (!r.cpha) begin
                n.miso = n.sh[7];
            end
        end else if (r.st == sfcc_pkg::SFCC_IDLE) begin
            n.sbusy = 1'b0;
            n.shift_empty_bit = 1'b1;
        end
        // Mode fault drops the master last, so it beats any write
        if (fault) begin
            n.mode_fault_flag = 1'b1;
            n.mst = 1'b0;
            n.en = 1'b0;
            n.st = sfcc_pkg::SFCC_IDLE;
        end
        // Pin drivers
        n.sck_oe_n = ~(r.en & r.mst);
        n.mosi_oe_n = ~(r.en & r.mst);
        n.miso_oe_n = ~r.act;
        n.nss_oe_n = ~r.select_mode_field[1];
        n.nsso = r.select_mode_field[0];
        n.irq = i_irq_en & (r.transfer_done_flag | r.write_collision_flag | r.mode_fault_flag | r.ovr);
        // Read port; unmapped addresses read zero
        n.rdata = 8'h00;
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                sfcc_pkg::ADDR_CTRL: n.rdata = {r.transfer_done_flag, r.write_collision_flag, r.mode_fault_flag, r.ovr, r.select_mode_field, r.txe, r.en};
                sfcc_pkg::ADDR_CFG: n.rdata = {(r.st == sfcc_pkg::SFCC_RUN) | r.sbusy, r.mst, r.cpha, r.cpol,
                                               ~r.nssf, r.nss_s[1], r.mst | r.shift_empty_bit, r.mst | r.rxe};
                sfcc_pkg::ADDR_RATE: n.rdata = r.ckr;
                sfcc_pkg::ADDR_DATA: n.rdata = r.rxb;
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r <= SYS_RST;
        end else begin
            r <= n;
        end
    end

    // Every output straight from the state
    assign o_sfr_rdata = r.rdata;
    assign o_irq = r.irq;
    assign o_sck = r.sck;
    assign o_sck_oe_n = r.sck_oe_n;
    assign o_mosi = r.mosi;
    assign o_mosi_oe_n = r.mosi_oe_n;
    assign o_miso = r.miso;
    assign o_miso_oe_n = r.miso_oe_n;
    assign o_nss = r.nsso;
    assign o_nss_oe_n = r.nss_oe_n;

    // Checks on the system clock
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    chk_write_collision_flag_set: assert property (wr_dat && !r.txe |=> r.write_collision_flag) else $error("collision flag missed");
    chk_write_collision_flag_keep: assert property (wr_dat && !r.txe |=> r.txb == $past(r.txb))
        else $error("colliding write stored");
    chk_fault_drop: assert property (fault |=> r.mode_fault_flag && !r.mst && !r.en) else $error("mode fault not taken");
    chk_irq_follow: assert property (i_irq_en && r.transfer_done_flag && !wr_ctl |=> ##1 o_irq)
        else $error("interrupt not raised");
    chk_busy_run: assert property (r.st == sfcc_pkg::SFCC_RUN && i_sfr_rd && i_sfr_addr == sfcc_pkg::ADDR_CFG
        |=> o_sfr_rdata[sfcc_pkg::CFG_BUSY]) else $error("busy bit low in transfer");
    chk_done_flag: assert property (r.st == sfcc_pkg::SFCC_RUN ##1 r.st == sfcc_pkg::SFCC_IDLE && !$past(fault)
        && $past(r.en) |-> r.transfer_done_flag) else $error("byte end without done flag");
    chk_idle_level: assert property (r.st == sfcc_pkg::SFCC_IDLE |=> o_sck == $past(r.cpol))
        else $error("clock not at idle level");
    chk_rate_limit: assert property (r.st == sfcc_pkg::SFCC_RUN && $changed(o_sck) |=> $stable(o_sck))
        else $error("half period too short");
    chk_ovr_keep: assert property (done && !r.rxe && !rd_dat |=> r.ovr && $stable(r.rxb))
        else $error("overrun lost old byte");

    cov_master_byte: cover property (r.st == sfcc_pkg::SFCC_RUN ##1 r.st == sfcc_pkg::SFCC_IDLE);
    cov_slave_byte: cover property (done);
    cov_collision: cover property (wr_dat && !r.txe);
    cov_mode_fault: cover property (fault);
endmodule : sfcc_core

// ===== tb/sfcc_peer.sv
// Far-side slave model for master-mode byte transfers.
// Assumes the bench resolves the pins and gives the peer the same phase and polarity.
`timescale 1ns/10ps
module sfcc_peer (
    input wire logic i_sck, // Resolved serial clock
    input wire logic i_mosi, // Resolved master-out line
    input wire logic i_cpol, // Idle clock level
    input wire logic i_cpha, // Sample on second edge when 1
    input wire logic [7:0] i_tx, // Byte sent back to the master
    input wire logic i_load, // Reload shifter and edge count while idle
    output logic o_miso, // Master-in drive
    output logic [7:0] o_rx // Byte captured from the master
);
    logic [7:0] sh = 8'h00;
    int e = 0;
    // Reload only while the clock stands still
    always @(posedge i_load) begin
        sh = i_tx;
        e = 0;
    end
    // Sample on one edge, shift on the other; spent bits refill inverted so stale data never looks valid
    always @(i_sck) begin
        if (!i_load) begin
            if (e % 2 == int'(i_cpha)) begin
                o_rx = {o_rx[6:0], i_mosi};
            end else if (!(i_cpha && e == 0)) begin
                sh = {sh[6:0], ~sh[7]};
            end
            e++;
        end
    end
    assign o_miso = sh[7];
endmodule : sfcc_peer

// ===== tb/tb_sfcc_core.sv
// Self-checking bench for the serial port flag, clocking and configuration block.
// Assumes sfcc_pkg and the peer model are compiled first.
`timescale 1ns/10ps
module tb_sfcc_core;
    logic i_clk_sys = 0;
    logic i_rst = 1;
    logic [7:0] i_sfr_addr = 8'h00;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_sfr_wr = 0;
    logic i_sfr_rd = 0;
    logic i_irq_en = 0;
    logic link_clk = 0;
    logic b_sck = 0;
    logic b_mosi = 0;
    logic b_nss = 1;
    logic cpol = 0;
    logic cpha = 0;
    logic p_load = 0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] p_rx;
    logic p_miso;
    logic [7:0] o_sfr_rdata, d;
    logic o_irq, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n, o_nss, o_nss_oe_n;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int gap = 0;
    int min_half = 99;
    logic sck_q = 0;
    // Pin resolution: whoever has its drive low owns the line
    wire sck_w = o_sck_oe_n ? b_sck : o_sck;
    wire mosi_w = o_mosi_oe_n ? b_mosi : o_mosi;
    wire miso_w = o_miso_oe_n ? p_miso : o_miso;
    wire nss_w = o_nss_oe_n ? b_nss : o_nss;

    sfcc_core DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
        .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_irq_en(i_irq_en),
        .o_irq(o_irq), .i_sck(sck_w), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .i_mosi(mosi_w),
        .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n), .i_miso(miso_w), .o_miso(o_miso),
        .o_miso_oe_n(o_miso_oe_n), .i_nss(nss_w), .o_nss(o_nss), .o_nss_oe_n(o_nss_oe_n));
    sfcc_peer PEER (.i_sck(sck_w), .i_mosi(mosi_w), .i_cpol(cpol), .i_cpha(cpha), .i_tx(p_tx),
        .i_load(p_load), .o_miso(p_miso), .o_rx(p_rx));

    // Clocks; link clock offset so it has no phase tie to the system clock
    always #10 i_clk_sys = ~i_clk_sys;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    // Hang guard plus shortest serial clock half period seen
    always @(negedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
        if (o_sck !== sck_q) begin
            if (gap < min_half) min_half = gap;
            gap = 1;
        end else gap++;
        sck_q = o_sck;
    end

    task automatic test_done();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_clk_sys);
        i_sfr_addr = a;
        i_sfr_wdata = v;
        i_sfr_wr = 1;
        @(negedge i_clk_sys);
        i_sfr_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge i_clk_sys);
        i_sfr_addr = a;
        i_sfr_rd = 1;
        @(negedge i_clk_sys);
        i_sfr_rd = 0;
        v = o_sfr_rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m, input string what);
        logic [7:0] v;
        rd(a, v);
        check(what, exp & m, v & m);
    endtask : rdc
    // Poll the control register, bounded
    task automatic wait_done();
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 300 && v[7] !== 1'b1; i++) rd(sfcc_pkg::ADDR_CTRL, v);
        check("done flag", 8'h80, v & 8'h80);
    endtask : wait_done
    // External master byte, mode 0; five link clocks per bit keeps it under a tenth of the system clock
    task automatic slave_byte(input logic [7:0] tx, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            @(posedge link_clk);
            b_mosi = tx[i];
            repeat (2) @(posedge link_clk);
            got[i] = miso_w;
            b_sck = 1;
            repeat (2) @(posedge link_clk);
            b_sck = 0;
        end
    endtask : slave_byte

    initial begin
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 0;
        rdc(sfcc_pkg::ADDR_CTRL, 8'h06, 8'hff, "ctrl reset");
        rdc(sfcc_pkg::ADDR_CFG, 8'h07, 8'hff, "cfg reset");
        rdc(sfcc_pkg::ADDR_RATE, 8'h00, 8'hff, "rate reset");
        rdc(8'h00, 8'h00, 8'hff, "unmapped");
        i_irq_en = 1;
        // Master, 3-wire, every phase and polarity, rate stepping 0..3
        for (int m = 0; m < 4; m++) begin
            cpol = m[0];
            cpha = m[1];
            wr(sfcc_pkg::ADDR_CTRL, 8'h00);
            wr(sfcc_pkg::ADDR_CFG, {2'b01, cpha, cpol, 4'h0});
            wr(sfcc_pkg::ADDR_RATE, 8'(m));
            wr(sfcc_pkg::ADDR_CTRL, 8'h01);
            p_tx = 8'h3c ^ 8'(m);
            repeat (3) @(negedge i_clk_sys);
            check("sck idle", {7'h00, cpol}, {7'h00, o_sck});
            p_load = 1;
            @(negedge i_clk_sys);
            p_load = 0;
            min_half = 99;
            // Back-to-back data writes: the second one collides
            @(negedge i_clk_sys);
            i_sfr_addr = sfcc_pkg::ADDR_DATA;
            i_sfr_wdata = 8'ha5 ^ 8'(m);
            i_sfr_wr = 1;
            @(negedge i_clk_sys);
            i_sfr_wdata = 8'h11;
            @(negedge i_clk_sys);
            i_sfr_wr = 0;
            rdc(sfcc_pkg::ADDR_CFG, 8'h80, 8'h80, "busy");
            wait_done();
            check("peer rx", 8'ha5 ^ 8'(m), p_rx);
            rdc(sfcc_pkg::ADDR_DATA, p_tx, 8'hff, "master rx");
            rdc(sfcc_pkg::ADDR_CTRL, 8'hc3, 8'hff, "flags");
            check("half period", 8'(m < 2 ? 2 : m + 1), 8'(min_half));
            check("irq set", 8'h01, {7'h00, o_irq});
            wr(sfcc_pkg::ADDR_CTRL, 8'h01);
            repeat (2) @(negedge i_clk_sys);
            check("irq clear", 8'h00, {7'h00, o_irq});
        end
        // Multi-master mode, select pulled low
        wr(sfcc_pkg::ADDR_CTRL, 8'h05);
        b_nss = 0;
        repeat (8) @(negedge i_clk_sys);
        rdc(sfcc_pkg::ADDR_CTRL, 8'h26, 8'hff, "mode fault");
        rdc(sfcc_pkg::ADDR_CFG, 8'h08, 8'h4c, "master off");
        check("irq fault", 8'h01, {7'h00, o_irq});
        // Slave, 4-wire, selected; rate register left at 3 must not matter
        wr(sfcc_pkg::ADDR_CFG, 8'h00);
        wr(sfcc_pkg::ADDR_CTRL, 8'h05);
        rdc(sfcc_pkg::ADDR_CFG, 8'h09, 8'h0d, "slave idle");
        wr(sfcc_pkg::ADDR_DATA, 8'h96);
        slave_byte(8'h5a, d);
        check("slave tx", 8'h96, d);
        repeat (10) @(negedge i_clk_sys);
        rdc(sfcc_pkg::ADDR_CTRL, 8'h80, 8'hf0, "slave done");
        rdc(sfcc_pkg::ADDR_CFG, 8'h00, 8'h81, "rx full");
        slave_byte(8'hc3, d);
        repeat (10) @(negedge i_clk_sys);
        rdc(sfcc_pkg::ADDR_CTRL, 8'h90, 8'hf0, "overrun");
        rdc(sfcc_pkg::ADDR_DATA, 8'h5a, 8'hff, "old byte");
        rdc(sfcc_pkg::ADDR_CFG, 8'h01, 8'h01, "rx empty");
        b_nss = 1;
        repeat (8) @(negedge i_clk_sys);
        rdc(sfcc_pkg::ADDR_CFG, 8'h04, 8'h0c, "deselected");
        // Select mode 11 drives the select line high
        wr(sfcc_pkg::ADDR_CTRL, 8'h0c);
        repeat (2) @(negedge i_clk_sys);
        check("nss drive", 8'h01, {6'h00, o_nss_oe_n, o_nss});
        test_done();
    end
endmodule : tb_sfcc_core
